/* src/board_id_guard.sv */
// Identification memory serial slave and host pin hold-off guard
`timescale 1ns/10ps
module board_id_guard #(
    parameter int BOOT_PINS  = 20,
    parameter int FLASH_PINS = 10,
    parameter bit ID_ROLE    = 1'b1
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // Identification bus and straps
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output      logic                  sda_out,
    output      logic                  sda_oe,
    input  wire logic [1:0]            addr_switch,
    input  wire logic                  write_protect,
    // Host reset and software enable
    input  wire logic                  host_system_reset_n,
    input  wire logic                  shared_pin_enable,
    // Outputs on host boot configuration pins
    input  wire logic [BOOT_PINS-1:0]  boot_config_data,
    output      logic [BOOT_PINS-1:0]  boot_config_pins,
    output      logic [BOOT_PINS-1:0]  boot_config_oe,
    // Outputs on pins shared with the on-board flash card
    input  wire logic [FLASH_PINS-1:0] flash_shared_data,
    output      logic [FLASH_PINS-1:0] flash_shared_pins,
    output      logic [FLASH_PINS-1:0] flash_shared_oe,
    // Removable-card boot strap
    input  wire logic                  force_card_boot,
    output      logic                  boot_select_strap,
    output      logic                  boot_select_strap_oe
);

    localparam int AW = board_id_pkg::MEM_AW;
    localparam int PB = board_id_pkg::PAGE_BYTES;
    localparam int PW = board_id_pkg::PAGE_AW;

    if (BOOT_PINS < 1 || FLASH_PINS < 1) begin : g_bad_pins
        $error("pin group widths must be at least one");
    end
    // Synchroniser plus edge detect must fit inside the shortest clock high
    if (board_id_pkg::FMP_SCL_HIGH_CYC < board_id_pkg::EDGE_LATENCY_CYC) begin : g_slow
        $error("system clock too slow for the fastest bus rate");
    end

    typedef struct packed {
        board_id_pkg::pins_t        s1;
        board_id_pkg::pins_t        s2;
        logic                       scl_d;
        logic                       sda_d;
        board_id_pkg::bus_state_t   st;
        board_id_pkg::byte_kind_t   kind;
        logic [3:0]                 bitcnt;
        logic [7:0]                 shreg;
        logic                       rd_next;
        logic [AW-1:0]              addr;
        logic [PB-1:0]              pend;
        logic [PB-1:0][7:0]         page;
        logic [PW-1:0]              cidx;
        logic                       sda_oe;
        logic [BOOT_PINS-1:0]       boot_q;
        logic [BOOT_PINS-1:0]       boot_oe;
        logic [FLASH_PINS-1:0]      flash_q;
        logic [FLASH_PINS-1:0]      flash_oe;
        logic                       strap_oe;
    } state_t;

    localparam state_t RESET_STATE = '0;

    function automatic logic [6:0] dev_addr_of(input logic strap, input logic [1:0] sel);
        dev_addr_of = {board_id_pkg::DEV_FAMILY, strap, sel};
    endfunction

    state_t        r;
    state_t        next_r;
    logic [7:0]    rdata;
    logic [6:0]    own_addr;
    logic          scl_rise;
    logic          scl_fall;
    logic          bus_start;
    logic          bus_stop;
    logic          byte_done;
    logic [PW-1:0] pidx;
    logic          mem_we;

    // Edge detection looks only at the second synchroniser stage
    assign scl_rise  = r.s2.scl & ~r.scl_d; // RULE6
    assign scl_fall  = ~r.s2.scl & r.scl_d;
    assign bus_start = r.s2.scl & r.scl_d & r.sda_d & ~r.s2.sda;
    assign bus_stop  = r.s2.scl & r.scl_d & ~r.sda_d & r.s2.sda;
    assign byte_done = (r.st == board_id_pkg::S_RX) && scl_fall && (r.bitcnt == 4'h8);
    // High strap ties to one for the identification part, to ground otherwise
    assign own_addr  = dev_addr_of(ID_ROLE, r.s2.addr_sel); // RULE1 RULE2 RULE3
    assign pidx      = r.addr[PW-1:0];
    assign mem_we    = (r.st == board_id_pkg::S_COMMIT) && r.pend[r.cidx];

    always_comb begin
        next_r = r;
        next_r.s1 = '{scl: scl, sda: sda_in, addr_sel: addr_switch, wp: write_protect,
                      host_rst_n: host_system_reset_n, flash_en: shared_pin_enable};
        next_r.s2    = r.s1;
        next_r.scl_d = r.s2.scl;
        next_r.sda_d = r.s2.sda;

        unique case (r.st)
            board_id_pkg::S_IDLE: begin
                next_r.sda_oe = 1'b0;
            end
            board_id_pkg::S_RX: begin
                if (scl_rise) begin
                    next_r.shreg  = {r.shreg[6:0], r.s2.sda};
                    next_r.bitcnt = r.bitcnt + 4'h1;
                end else if (byte_done) begin
                    next_r.bitcnt  = 4'h0;
                    next_r.st      = board_id_pkg::S_ACK;
                    next_r.sda_oe  = 1'b1;
                    unique case (r.kind)
                        board_id_pkg::K_DEV: begin
                            if (r.shreg[7:1] != own_addr) begin // RULE1
                                next_r.st     = board_id_pkg::S_IDLE;
                                next_r.sda_oe = 1'b0;
                            end else begin
                                next_r.rd_next = r.shreg[0];
                                next_r.kind    = board_id_pkg::K_AHI;
                            end
                        end
                        board_id_pkg::K_AHI: begin
                            // Top bit beyond the array is ignored
                            next_r.addr[AW-1:8] = r.shreg[AW-9:0]; // RULE7 RULE14
                            next_r.kind         = board_id_pkg::K_ALO;
                        end
                        board_id_pkg::K_ALO: begin
                            next_r.addr[7:0] = r.shreg; // RULE7 RULE14
                            next_r.kind      = board_id_pkg::K_WR;
                            next_r.pend      = '0;
                        end
                        board_id_pkg::K_WR: begin
                            if (r.s2.wp) begin
                                next_r.sda_oe = 1'b0; // RULE16
                            end else begin
                                // Address wraps inside the page, as a page buffer does
                                next_r.page[pidx]       = r.shreg; // RULE5
                                next_r.pend[pidx]       = 1'b1;
                                next_r.addr[PW-1:0]     = pidx + PW'(1);
                            end
                        end
                    endcase
                end
            end
            board_id_pkg::S_ACK: begin
                if (scl_fall) begin
                    if (r.rd_next) begin
                        next_r.st     = board_id_pkg::S_TX;
                        next_r.shreg  = rdata;
                        next_r.sda_oe = ~rdata[7];
                    end else begin
                        next_r.st     = board_id_pkg::S_RX;
                        next_r.sda_oe = 1'b0;
                    end
                end
            end
            board_id_pkg::S_TX: begin
                if (scl_fall) begin
                    if (r.bitcnt == 4'h7) begin
                        next_r.st     = board_id_pkg::S_TXACK;
                        next_r.sda_oe = 1'b0;
                        next_r.bitcnt = 4'h0;
                        next_r.addr   = r.addr + AW'(1); // RULE14
                    end else begin
                        next_r.shreg  = {r.shreg[6:0], 1'b0};
                        next_r.sda_oe = ~r.shreg[6];
                        next_r.bitcnt = r.bitcnt + 4'h1;
                    end
                end
            end
            board_id_pkg::S_TXACK: begin
                if (scl_rise) begin
                    next_r.rd_next = ~r.s2.sda;
                end else if (scl_fall) begin
                    if (r.rd_next) begin
                        next_r.st     = board_id_pkg::S_TX;
                        next_r.shreg  = rdata;
                        next_r.sda_oe = ~rdata[7];
                    end else begin
                        next_r.st = board_id_pkg::S_IDLE;
                    end
                end
            end
            board_id_pkg::S_COMMIT: begin
                next_r.sda_oe = 1'b0;
                next_r.cidx   = r.cidx + PW'(1);
                if (r.cidx == PW'(PB - 1)) begin
                    next_r.st   = board_id_pkg::S_IDLE;
                    next_r.pend = '0;
                end
            end
            default: begin
                next_r.st = board_id_pkg::S_IDLE;
            end
        endcase

        // Bus is ignored while a page commits, so the host sees no answer and polls
        if (r.st != board_id_pkg::S_COMMIT && (bus_start || bus_stop)) begin
            next_r.sda_oe = 1'b0;
            next_r.bitcnt = 4'h0;
            next_r.cidx   = '0;
            if (|r.pend) begin
                next_r.st = board_id_pkg::S_COMMIT; // RULE5
            end else if (bus_start) begin
                next_r.st   = board_id_pkg::S_RX;
                next_r.kind = board_id_pkg::K_DEV;
            end else begin
                next_r.st = board_id_pkg::S_IDLE;
            end
        end

        // Pin guard
        next_r.boot_q   = boot_config_data;
        next_r.boot_oe  = {BOOT_PINS{r.s2.host_rst_n}}; // RULE10
        next_r.flash_q  = flash_shared_data;
        next_r.flash_oe = {FLASH_PINS{r.s2.host_rst_n & r.s2.flash_en}}; // RULE12
        next_r.strap_oe = force_card_boot & ~r.s2.host_rst_n; // RULE11
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= RESET_STATE;
        end else begin
            r <= next_r;
        end
    end

    id_byte_memory #(
        .DEPTH (board_id_pkg::MEM_BYTES),
        .AW    (AW)
    ) u_mem (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr ({r.addr[AW-1:PW], r.cidx}),
        .wdata (r.page[r.cidx]),
        .raddr (r.addr),
        .rdata (rdata)
    );

    assign sda_out              = 1'b0;
    assign sda_oe               = r.sda_oe;
    assign boot_config_pins     = r.boot_q;
    assign boot_config_oe       = r.boot_oe;
    assign flash_shared_pins    = r.flash_q;
    assign flash_shared_oe      = r.flash_oe;
    assign boot_select_strap    = 1'b0;
    assign boot_select_strap_oe = r.strap_oe;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence dev_byte_done;
        byte_done && r.kind == board_id_pkg::K_DEV;
    endsequence

    sequence wr_byte_done;
        byte_done && r.kind == board_id_pkg::K_WR;
    endsequence

    a_dev_ack_range: assert property ( // RULE1
        dev_byte_done |=> r.sda_oe == (($past(r.shreg[7:1]) | 7'h04) >= board_id_pkg::ID_ADDR_LO
            && ($past(r.shreg[7:1]) | 7'h04) <= board_id_pkg::ID_ADDR_HI
            && $past(r.shreg[3]) == ID_ROLE
            && $past(r.shreg[2:1]) == $past(r.s2.addr_sel)))
        else $error("device address answer outside the identification range");

    a_switch_mismatch: assert property ( // RULE2
        dev_byte_done and (r.shreg[2:1] != r.s2.addr_sel) |=> r.st == board_id_pkg::S_IDLE)
        else $error("answered an address not set by the switch");

    a_strap_family: assert property ( // RULE3
        dev_byte_done and (r.shreg[3] != ID_ROLE) |=> !r.sda_oe ##1 !r.sda_oe)
        else $error("answered with the wrong high strap");

    a_page_commit: assert property ( // RULE5
        $rose(r.st == board_id_pkg::S_COMMIT) |-> ##64 r.st == board_id_pkg::S_IDLE)
        else $error("page commit did not last one full page");

    a_word_addr_lo: assert property ( // RULE7
        byte_done && r.kind == board_id_pkg::K_ALO
        |=> r.addr[7:0] == $past(r.shreg) && r.kind == board_id_pkg::K_WR)
        else $error("low word address byte not taken");

    a_read_incr: assert property ( // RULE14
        r.st == board_id_pkg::S_TX && scl_fall && r.bitcnt == 4'h7
        |=> r.addr == $past(r.addr) + AW'(1))
        else $error("read address did not advance");

    a_wp_refuse: assert property ( // RULE16
        wr_byte_done and r.s2.wp |=> !r.sda_oe && $stable(r.pend))
        else $error("write accepted while protected");

    a_boot_hold: assert property ( // RULE10
        !r.s2.host_rst_n |=> boot_config_oe == '0)
        else $error("boot pins driven during host reset");

    a_flash_hold: assert property ( // RULE12
        !(r.s2.host_rst_n && r.s2.flash_en) |=> flash_shared_oe == '0)
        else $error("flash-shared pins driven without enable");

    a_strap_gate: assert property ( // RULE11
        boot_select_strap_oe |-> $past(!r.s2.host_rst_n) && $past(force_card_boot))
        else $error("boot strap driven outside reset");

endmodule

/* src/board_id_pkg.sv */
// Constants and types for the expansion board identification memory and pin guard
//
// Summary of operation
// RULE1: Answer only at bus addresses 0x54..0x57.
// RULE2: Two low address bits come from switch.
// RULE3: Other family memories ground the high strap.
// RULE4: Array holds 32,768 single-byte readable locations.
// RULE5: Writes collect in 64-byte page buffer first.
// RULE6: Serial slave works at 100k, 400k, 1 MHz.
// RULE7: Every access carries a two-byte word address; a read device byte here reads on from the current address.
// RULE8: Host keeps identification bus on header pins.
// RULE9: Host enables pull-ups when no board attached.
// RULE10: Boot-config outputs undriven until host reset releases.
// RULE11: Boot strap pulled low only during reset.
// RULE12: Flash-shared outputs float until software enables them.
// RULE13: Host resets flash card before enabling pins.
// RULE14: Address high byte first; reads auto-increment.
// RULE15: Contents big-endian, header AA 55 33 EE.
// RULE16: Writes refused while write-protect input high.
package board_id_pkg;

    localparam logic [3:0] DEV_FAMILY    = 4'hA;
    localparam logic       ID_HIGH_STRAP = 1'h1;
    localparam logic [6:0] ID_ADDR_LO    = 7'h54;
    localparam logic [6:0] ID_ADDR_HI    = 7'h57;

    localparam int MEM_BYTES  = 32'h0000_8000;
    localparam int MEM_AW     = 32'h0000_000F;
    localparam int PAGE_BYTES = 32'h0000_0040;
    localparam int PAGE_AW    = 32'h0000_0006;

    localparam logic [7:0] HDR_BYTE0 = 8'hAA;
    localparam logic [7:0] HDR_BYTE1 = 8'h55;
    localparam logic [7:0] HDR_BYTE2 = 8'h33;
    localparam logic [7:0] HDR_BYTE3 = 8'hEE;

    // Shortest serial clock high phase at the fastest bus rate
    localparam int MCLK_PERIOD_NS   = 32'h0000_0019;
    localparam int FMP_SCL_HIGH_NS  = 32'h0000_0104;
    localparam int FMP_SCL_HIGH_CYC = FMP_SCL_HIGH_NS / MCLK_PERIOD_NS;
    localparam int EDGE_LATENCY_CYC = 32'h0000_0004;

    typedef enum logic [2:0] {
        S_IDLE   = 3'h0,
        S_RX     = 3'h1,
        S_ACK    = 3'h2,
        S_TX     = 3'h3,
        S_TXACK  = 3'h4,
        S_COMMIT = 3'h5
    } bus_state_t;

    typedef enum logic [1:0] {
        K_DEV = 2'h0,
        K_AHI = 2'h1,
        K_ALO = 2'h2,
        K_WR  = 2'h3
    } byte_kind_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic [1:0] addr_sel;
        logic       wp;
        logic       host_rst_n;
        logic       flash_en;
    } pins_t;

endpackage

/* src/id_byte_memory.sv */
// Byte-wide storage array with one write port and a registered read port
`timescale 1ns/10ps
module id_byte_memory #(
    parameter int DEPTH = board_id_pkg::MEM_BYTES,
    parameter int AW    = board_id_pkg::MEM_AW
) (
    // Clock
    input  wire logic          mclk,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output      logic [7:0]    rdata
);

    if (DEPTH != (1 << AW) || DEPTH < 4) begin : g_bad_depth
        $error("memory depth must be a power of two matching the address width");
    end

    logic [7:0] mem [DEPTH];

    // Blank image with the identification header at location zero
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = 8'h00;
        end
        mem[0] = board_id_pkg::HDR_BYTE0; // RULE15
        mem[1] = board_id_pkg::HDR_BYTE1; // RULE15
        mem[2] = board_id_pkg::HDR_BYTE2; // RULE15
        mem[3] = board_id_pkg::HDR_BYTE3; // RULE15
    end

    // Plain always: the initial image above also writes the array
    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr]; // RULE4
    end

endmodule

/* bench/host_bus_model.sv */
// Host serial controller and GPIO model facing the identification slave
`timescale 1ns/10ps
module host_bus_model (
    // Clock
    input  wire logic mclk,
    // Identification bus
    input  wire logic dev_sda_oe,
    output      logic scl,
    output      wire  sda_line,
    // Host GPIO
    output      logic host_system_reset_n,
    output      logic shared_pin_enable,
    output      logic flash_card_reset_n
);
    int   half;
    logic host_low;

    // Lines stay routed and pulled up, so a released line reads high
    assign sda_line = ~(host_low | dev_sda_oe);

    initial begin
        half = 20;
        host_low = 1'b0;
        scl = 1'b1;
        host_system_reset_n = 1'b0;
        shared_pin_enable = 1'b0;
        flash_card_reset_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Data moves only in the middle of the low phase, never near a clock edge
    task automatic put_bit(input logic b, output logic r);
        tick(half / 2);
        host_low <= ~b;
        tick(half - half / 2);
        scl <= 1'b1;
        tick(half);
        r = sda_line;
        scl <= 1'b0;
    endtask

    task automatic start_cond();
        tick(half / 2);
        host_low <= 1'b0;
        tick(half - half / 2);
        scl <= 1'b1;
        tick(half);
        host_low <= 1'b1;
        tick(half);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(half / 2);
        host_low <= 1'b1;
        tick(half - half / 2);
        scl <= 1'b1;
        tick(half);
        host_low <= 1'b0;
        tick(half);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(last, r);
    endtask

    task automatic send_addr(input logic [6:0] dev, input logic [15:0] addr,
                             output logic [2:0] acks);
        start_cond();
        send_byte({dev, 1'b0}, acks[2]);
        send_byte(addr[15:8], acks[1]);
        send_byte(addr[7:0], acks[0]);
    endtask

    task automatic release_host_reset();
        @(posedge mclk);
        host_system_reset_n <= 1'b1;
    endtask

    // The flash card goes into reset before the shared pins may be driven
    task automatic enable_shared();
        @(posedge mclk);
        flash_card_reset_n <= 1'b0;
        tick(4);
        shared_pin_enable <= 1'b1;
    endtask
endmodule

/* bench/tb_board_id_guard.sv */
// Self-checking testbench for the identification slave and pin guard
`timescale 1ns/10ps
module tb_board_id_guard;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  addr_switch = 2'h0;
    logic        write_protect = 1'b1;
    logic [19:0] boot_config_data = 20'hA5C3E;
    logic [9:0]  flash_shared_data = 10'h2D7;
    logic        force_card_boot = 1'b1;
    wire         scl, sda_line, sda_oe, sda_drive_level, host_rst_n, shared_en, flash_rst_n;
    wire  [19:0] boot_config_pins, boot_config_oe;
    wire  [9:0]  flash_shared_pins, flash_shared_oe;
    wire         boot_select_strap, boot_select_strap_oe;
    wire  [6:0]  dev_id = {5'h15, addr_switch};
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    board_id_guard DUT (
        .mclk                 (mclk),
        .srst                 (srst),
        .scl                  (scl),
        .sda_in               (sda_line),
        .sda_out              (sda_drive_level),
        .sda_oe               (sda_oe),
        .addr_switch          (addr_switch),
        .write_protect        (write_protect),
        .host_system_reset_n  (host_rst_n),
        .shared_pin_enable    (shared_en),
        .boot_config_data     (boot_config_data),
        .boot_config_pins     (boot_config_pins),
        .boot_config_oe       (boot_config_oe),
        .flash_shared_data    (flash_shared_data),
        .flash_shared_pins    (flash_shared_pins),
        .flash_shared_oe      (flash_shared_oe),
        .force_card_boot      (force_card_boot),
        .boot_select_strap    (boot_select_strap),
        .boot_select_strap_oe (boot_select_strap_oe)
    );

    host_bus_model host (
        .mclk                (mclk),
        .dev_sda_oe          (sda_oe),
        .scl                 (scl),
        .sda_line            (sda_line),
        .host_system_reset_n (host_rst_n),
        .shared_pin_enable   (shared_en),
        .flash_card_reset_n  (flash_rst_n)
    );

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic read_check(input logic [15:0] addr, input logic [31:0] exp, input int n);
        logic [2:0] acks;
        logic       ack;
        logic [7:0] d;
        host.send_addr(dev_id, addr, acks);
        host.start_cond();
        host.send_byte({dev_id, 1'b1}, ack);
        check({acks, ack}, 32'hF);
        for (int i = 0; i < n; i++) begin
            host.recv_byte(i == n - 1, d);
            check(d, exp[31 - 8 * i -: 8]);
        end
        host.stop_cond();
    endtask

    // Waits out the page commit, during which the slave ignores the bus
    task automatic write_bytes(input logic [15:0] addr, input logic [31:0] data, input int n,
                               input logic exp_ack);
        logic [2:0] acks;
        logic       ack;
        host.send_addr(dev_id, addr, acks);
        check(acks, 32'h7);
        for (int i = 0; i < n; i++) begin
            host.send_byte(data[31 - 8 * i -: 8], ack);
            check(ack, {31'h0, exp_ack});
        end
        host.stop_cond();
        repeat (70) @(posedge mclk);
    endtask

    task automatic test_pin_guard();
        @(negedge mclk);
        check(boot_config_oe, 32'h0);
        check(flash_shared_oe, 32'h0);
        check(boot_select_strap_oe, 32'h1);
        check(boot_select_strap, 32'h0);
        check(sda_drive_level, 32'h0);
        check(flash_rst_n, 32'h1);
        host.release_host_reset();
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check(boot_config_oe, 32'hF_FFFF);
        check(boot_config_pins, boot_config_data);
        check(boot_select_strap_oe, 32'h0);
        check(flash_shared_oe, 32'h0);
        host.enable_shared();
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check(flash_shared_oe, 32'h3FF);
        check(flash_shared_pins, flash_shared_data);
        check(flash_rst_n, 32'h0);
        $display("test_pin_guard done");
    endtask

    task automatic test_addr_decode();
        logic ack;
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            addr_switch <= s[1:0];
            repeat (8) @(posedge mclk);
            for (int a = 32'h50; a < 32'h58; a++) begin
                host.start_cond();
                host.send_byte({a[6:0], 1'b0}, ack);
                host.stop_cond();
                check(ack, {31'h0, a == (32'h54 | s)});
            end
        end
        $display("test_addr_decode done");
    endtask

    task automatic test_rates();
        int halves[3] = '{200, 50, 20};
        foreach (halves[i]) begin
            host.half = halves[i];
            read_check(16'h0000, 32'hAA5533EE, 4);
        end
        $display("test_rates done");
    endtask

    task automatic test_write_read();
        write_bytes(16'h0100, 32'hA700_0000, 1, 1'b0);
        read_check(16'h0100, 32'h0, 1);
        @(posedge mclk);
        write_protect <= 1'b0;
        repeat (8) @(posedge mclk);
        write_bytes(16'h0040, 32'hC35A_9600, 3, 1'b1);
        read_check(16'h0040, 32'hC35A_9600, 4);
        write_bytes(16'h007F, 32'h1122_0000, 2, 1'b1);
        read_check(16'h007F, 32'h1100_0000, 2);
        read_check(16'h0040, 32'h225A_0000, 2);
        $display("test_write_read done");
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        test_pin_guard();
        test_addr_decode();
        test_rates();
        test_write_read();
        complete_run();
    end

    // Whole run is near 73000 cycles, the largest share of it the slowest bus rate
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, cycles, 32'h0);
            complete_run();
        end
    end
endmodule
